/* wwdt_pkg.sv */
// Package: constants of the windowed watchdog timer
`default_nettype none
package wwdt_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0]  OFS_SERVICE    = 8'h00;
  localparam logic [7:0]  OFS_CAUSE      = 8'h04;
  localparam logic [7:0]  OFS_COUNT      = 8'h08;
  // Service register values
  localparam logic [7:0]  SVC_KEY        = 8'hac;
  localparam logic [7:0]  SVC_READ_RUN   = 8'h9a;
  localparam logic [7:0]  SVC_READ_STOP  = 8'h1a;
  // Option byte field positions
  localparam int          OPT_LOCK_BIT   = 0;
  localparam int          OPT_OVF_LSB    = 1;
  localparam int          OPT_RUN_BIT    = 4;
  localparam int          OPT_WIN_LSB    = 5;
  // Cause register field and reset value
  localparam int          CAUSE_WDT_BIT  = 4;
  localparam logic        CAUSE_RESET    = 1'b0;
  // Counter geometry: overflow is 2^(10+select) ticks
  localparam int          CNT_W          = 18;
  localparam logic [CNT_W-1:0] OVF_BASE  = 18'h00400;
  // Data accesses at or above this address are never illegal
  localparam logic [15:0] EXEMPT_BASE    = 16'hfb00;
  // Timing: bus clock and low-speed oscillator period
  localparam int          CLK_PERIOD_NS  = 100;
  localparam int          LS_PERIOD_NS   = 4167;
  localparam int          LS_DIV         = LS_PERIOD_NS / CLK_PERIOD_NS;
  localparam int          LS_DIV_W       = 16;
  // Bus encodings
  localparam logic        HRESP_OKAY     = 1'b0;
  localparam int          HTRANS_NSEQ_B  = 1;
endpackage
`default_nettype wire

/* wwdt_tick.sv */
// Low-speed oscillator model: tick pulse every div clocks while running
`default_nettype none
module wwdt_tick
  import wwdt_pkg::*;
(
  // Clock and control
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic                ce,
  input  wire logic                osc_run,
  input  wire logic [LS_DIV_W-1:0] div,
  // Tick out
  output logic                     tick
);
  logic [LS_DIV_W-1:0] div_reg;

  // A stopped oscillator holds its phase, so no tick leaks out
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_reg <= '0;
    end else if (ce && osc_run) begin
      if (div_reg >= div - 16'h0001) begin
        div_reg <= '0;
      end else begin
        div_reg <= div_reg + 16'h0001;
      end
    end
  end

  assign tick = ce && osc_run && (div_reg >= div - 16'h0001);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_tick_stopped: assert property (!osc_run |-> !tick)
    else $error("tick while oscillator stopped");
endmodule
`default_nettype wire

/* wwdt_area_chk.sv */
// Address map check for one access stream
`default_nettype none
module wwdt_area_chk
  import wwdt_pkg::*;
(
  // Access
  input  wire logic        valid,
  input  wire logic [15:0] addr,
  input  wire logic        exempt_top,
  // Configured areas
  input  wire logic [15:0] rom_limit,
  input  wire logic [15:0] ram_base,
  // Result
  output logic             bad
);
  logic in_rom;
  logic in_ram;
  logic exempt;

  assign in_rom = addr <= rom_limit;
  assign in_ram = addr >= ram_base;
  assign exempt = exempt_top && (addr >= EXEMPT_BASE);
  assign bad    = valid && !in_rom && !in_ram && !exempt;
endmodule
`default_nettype wire

/* wwdt_top.sv */
// Windowed watchdog timer with AHB-Lite register slave
// Contract
// - Run-enable option starts counter and illegal-access detection; else both stay off.
// - With counting enabled, counter runs from reset release without software.
// - Key write before overflow clears counter and restarts from zero.
// - After first service write, writes in closed window raise internal reset.
// - Overflow without valid key write raises internal reset.
// - Bit-manipulation instruction on service register raises internal reset.
// - Any non-key value written to service register raises internal reset.
// - With detection on, fetch outside configured memory raises reset.
// - With detection on, data access outside memory resets; top range exempt.
// - First service write after reset clears even inside closed window.
// - Overflow time after a clear may deviate by two low-speed periods.
// - Key write in last count before overflow still clears counter.
// - Lock option 0 halts count in HALT/STOP; 1 keeps counting.
// - Lock 0 and oscillator stopped by software freezes count, no clear.
// - Counting continues during flash self-programming and data emulation.
// - Overflow select codes 0 to 7 give 2^10 to 2^17 ticks.
// - Window codes 0 to 3 open 25, 50, 75, 100 percent.
// - Service register reads 9A when running, 1A when disabled.
// - A watchdog reset sets the watchdog cause flag.
// - Service violation while source clock stopped resets when it resumes.
`default_nettype none
module wwdt_top
  import wwdt_pkg::*;
#(
  parameter logic [LS_DIV_W-1:0] LS_DIVIDE = LS_DIV[LS_DIV_W-1:0]
) (
  // Clock, reset, enable
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic               ce,
  // AHB-Lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic [31:0]             hrdata,
  output logic                    hresp,
  // Option byte and power state
  input  wire logic [7:0]         option_byte,
  input  wire logic               halt_mode,
  input  wire logic               stop_mode,
  input  wire logic               lowspeed_osc_halt,
  // CPU activity
  input  wire logic               bit_manip_svc,
  input  wire logic               fetch_valid,
  input  wire logic [15:0]        fetch_addr,
  input  wire logic               data_valid,
  input  wire logic [15:0]        data_addr,
  input  wire logic [15:0]        mem_rom_limit,
  input  wire logic [15:0]        mem_ram_base,
  // Results
  output logic                    wdt_reset_req,
  output logic                    wdt_reset_cause_flag,
  output logic                    window_open
);
  // Option byte, caught in the reset cycle (straps)
  logic             wdt_run_enable;
  logic             lowspeed_osc_lock;
  logic [2:0]       ovf_sel;
  logic [1:0]       open_sel;
  // Counter and sequencing state
  logic [CNT_W-1:0] cnt_reg;
  logic             first_done_reg;
  logic             pend_reg;
  // Bus data phase
  logic             dp_valid_reg;
  logic             dp_write_reg;
  logic [7:0]       dp_addr_reg;
  // Combinational
  logic             tick;
  logic             osc_run;
  logic             cnt_run;
  logic [CNT_W-1:0] limit;
  logic [CNT_W-1:0] quarter;
  logic [CNT_W-1:0] closed_end;
  logic             win_closed;
  logic             svc_wr;
  logic             key_ok;
  logic             svc_bad;
  logic             overflow;
  logic             fetch_bad;
  logic             data_bad;
  logic             illegal;
  logic             fire;
  logic             addr_ph;
  logic [7:0]       svc_read;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wdt_run_enable    <= option_byte[OPT_RUN_BIT];
      lowspeed_osc_lock <= option_byte[OPT_LOCK_BIT];
      ovf_sel           <= option_byte[OPT_OVF_LSB +: 3];
      open_sel          <= option_byte[OPT_WIN_LSB +: 2];
    end
  end

  // Oscillator only stoppable by software while unlocked
  assign osc_run = lowspeed_osc_lock || !lowspeed_osc_halt;

  wwdt_tick u_tick (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ce      (ce),
    .osc_run (osc_run),
    .div     (LS_DIVIDE),
    .tick    (tick)
  );

  // Flash programming has no input here, so it cannot pause the count
  assign cnt_run = wdt_run_enable && tick
                   && (lowspeed_osc_lock || !(halt_mode || stop_mode));

  assign limit   = OVF_BASE << ovf_sel;
  assign quarter = limit >> 2;

  // Closed part counted from the clear point
  always_comb begin
    unique case (open_sel)
      2'b00:   closed_end = limit - quarter;
      2'b01:   closed_end = quarter << 1;
      2'b10:   closed_end = quarter;
      2'b11:   closed_end = '0;
    endcase
  end

  assign win_closed = cnt_reg < closed_end;

  assign svc_wr  = ce && dp_valid_reg && dp_write_reg
                   && (dp_addr_reg == OFS_SERVICE);
  assign key_ok  = svc_wr && (hwdata[7:0] == SVC_KEY)
                   && (!first_done_reg || !win_closed);
  assign svc_bad = (svc_wr && !key_ok) || (ce && bit_manip_svc);
  // Key in the last count wins over the overflow
  assign overflow = cnt_run && (cnt_reg == limit - 18'h00001)
                    && !key_ok;

  wwdt_area_chk u_fetch_chk (
    .valid      (fetch_valid),
    .addr       (fetch_addr),
    .exempt_top (1'b0),
    .rom_limit  (mem_rom_limit),
    .ram_base   (mem_ram_base),
    .bad        (fetch_bad)
  );

  wwdt_area_chk u_data_chk (
    .valid      (data_valid),
    .addr       (data_addr),
    .exempt_top (1'b1),
    .rom_limit  (mem_rom_limit),
    .ram_base   (mem_ram_base),
    .bad        (data_bad)
  );

  assign illegal = ce && wdt_run_enable && (fetch_bad || data_bad);
  // Service violations are timed by the source clock, so they wait for it
  assign fire = overflow || illegal || (tick && (pend_reg || svc_bad));

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pend_reg <= 1'b0;
    end else if (ce) begin
      if (fire) begin
        pend_reg <= 1'b0;
      end else if (svc_bad) begin
        pend_reg <= 1'b1;
      end
    end
  end

  // Counter; a watchdog reset also restarts the watchdog itself
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (ce) begin
      if (fire || key_ok) begin
        cnt_reg <= '0;
      end else if (cnt_run) begin
        cnt_reg <= cnt_reg + 18'h00001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      first_done_reg <= 1'b0;
    end else if (ce) begin
      if (fire) begin
        first_done_reg <= 1'b0;
      end else if (key_ok) begin
        first_done_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wdt_reset_req <= 1'b0;
      window_open   <= 1'b0;
    end else if (ce) begin
      wdt_reset_req <= fire;
      window_open   <= !first_done_reg || !win_closed;
    end
  end

  // AHB-Lite address phase; zero wait states
  assign addr_ph  = ce && hsel && hready && htrans[HTRANS_NSEQ_B];
  assign svc_read = wdt_run_enable ? SVC_READ_RUN : SVC_READ_STOP;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_addr_reg  <= '0;
    end else if (ce && hready) begin
      dp_valid_reg <= addr_ph;
      dp_write_reg <= hwrite;
      dp_addr_reg  <= haddr[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
      if (addr_ph && !hwrite) begin
        unique case (haddr[7:0])
          OFS_SERVICE: hrdata <= {24'h000000, svc_read};
          OFS_CAUSE:   hrdata <= {27'h0000000, wdt_reset_cause_flag,
                                  4'h0};
          OFS_COUNT:   hrdata <= {14'h0000, cnt_reg};
          default:     hrdata <= '0;
        endcase
      end
    end
  end

  // Cause flag: read clears, a new watchdog reset wins over the clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wdt_reset_cause_flag <= CAUSE_RESET;
    end else if (ce) begin
      if (fire) begin
        wdt_reset_cause_flag <= 1'b1;
      end else if (addr_ph && !hwrite && haddr[7:0] == OFS_CAUSE) begin
        wdt_reset_cause_flag <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_svc_read;
    addr_ph && !hwrite && haddr[7:0] == OFS_SERVICE;
  endsequence

  sequence s_frozen_step;
    ce && !svc_wr && !illegal && !pend_reg && !bit_manip_svc;
  endsequence

  a_key_clears: assert property (key_ok && !illegal |=> cnt_reg == '0)
    else $error("key write did not clear counter");
  a_closed_write: assert property (
    svc_wr && first_done_reg && win_closed && !tick && !illegal
    |=> pend_reg && first_done_reg)
    else $error("closed window write not flagged");
  a_overflow_rst: assert property (
    overflow |=> wdt_reset_req && cnt_reg == '0)
    else $error("overflow without reset");
  a_bit_manip: assert property (
    ce && bit_manip_svc && tick |=> wdt_reset_req)
    else $error("bit manipulation not reset");
  a_wrong_key: assert property (
    svc_wr && hwdata[7:0] != SVC_KEY |=> pend_reg || wdt_reset_req)
    else $error("wrong key not caught");
  a_fetch_bad: assert property (
    ce && wdt_run_enable && fetch_bad |=> wdt_reset_req)
    else $error("illegal fetch not reset");
  a_data_exempt: assert property (
    ce && data_valid && data_addr >= EXEMPT_BASE && !fetch_valid
    && !overflow && !tick |=> !wdt_reset_req)
    else $error("exempt data access reset");
  a_first_write: assert property (
    svc_wr && !first_done_reg && hwdata[7:0] == SVC_KEY && !illegal
    && !pend_reg
    |=> !wdt_reset_req && cnt_reg == '0 && first_done_reg)
    else $error("first write refused");
  a_halt_hold: assert property (
    s_frozen_step ##0 (!lowspeed_osc_lock && (halt_mode || stop_mode))
    |=> cnt_reg == $past(cnt_reg))
    else $error("count moved in halt");
  a_osc_hold: assert property (
    s_frozen_step ##0 (!osc_run) |=> $stable(cnt_reg))
    else $error("count moved with oscillator off");
  a_run_disabled: assert property (!wdt_run_enable |-> cnt_reg == '0)
    else $error("counter ran while disabled");
  a_read_value: assert property (s_svc_read |=> hrdata[7:0] ==
    (wdt_run_enable ? SVC_READ_RUN : SVC_READ_STOP))
    else $error("service read pattern wrong");
  a_cause_set: assert property (wdt_reset_req |-> wdt_reset_cause_flag)
    else $error("cause flag not set");
  a_pend_resume: assert property (
    pend_reg && ce && tick |=> wdt_reset_req && !pend_reg)
    else $error("pending violation not issued");
endmodule
`default_nettype wire

/* wwdt_cpu.sv */
// CPU model: bus master and access streams for the watchdog bench
`default_nettype none
module wwdt_cpu (
  // Clock
  input  wire logic        ref_clk,
  // Bus master
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic [1:0]       htrans,
  output logic [31:0]      haddr,
  output logic             hwrite,
  output logic [31:0]      hwdata,
  // Access streams
  output logic             fetch_valid,
  output logic             data_valid,
  output logic             bit_manip_svc,
  output logic [15:0]      acc_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {htrans, haddr, hwrite, hwdata} = '0;
    {fetch_valid, data_valid, bit_manip_svc, acc_addr} = '0;
  end
  // Single word; released lines flip so stale data never looks valid
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    @(posedge ref_clk);
    htrans <= 2'h2;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    haddr  <= ~haddr;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    r = hrdata;
    hwdata <= ~d;
  endtask
  // Kind 0 fetch, 1 data access, 2 bit operation on service register
  task automatic access(input logic [1:0] k, input logic [15:0] a);
    @(posedge ref_clk);
    fetch_valid   <= (k == 2'h0);
    data_valid    <= (k == 2'h1);
    bit_manip_svc <= (k == 2'h2);
    acc_addr      <= a;
    @(posedge ref_clk);
    {fetch_valid, data_valid, bit_manip_svc} <= 3'h0;
    acc_addr <= ~a;
  endtask
endmodule
`default_nettype wire

/* test_wwdt_top.sv */
// Self-checking bench for the windowed watchdog
`default_nettype none
module test_wwdt_top;
  timeunit 1ns;
  timeprecision 1ns;
  import wwdt_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic [7:0]  option_byte = 8'h00;
  logic        halt_mode = 1'b0;
  logic        stop_mode = 1'b0;
  logic        lowspeed_osc_halt = 1'b0;
  logic        hready, hwrite, hresp, fetch_valid, data_valid;
  logic        bit_manip_svc, wdt_reset_req, wdt_reset_cause_flag;
  logic        window_open;
  logic [1:0]  htrans;
  logic [15:0] acc_addr;
  logic [31:0] haddr, hwdata, hrdata, rd, k;
  int          n_fail = 0;
  int          n_checks = 0;
  int          n, w;
  initial forever #50 ref_clk = ~ref_clk;
  // Short low-speed period keeps overflow runs within a few thousand cycles
  wwdt_top #(.LS_DIVIDE(16'h0002)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
    .option_byte(option_byte), .halt_mode(halt_mode),
    .stop_mode(stop_mode), .lowspeed_osc_halt(lowspeed_osc_halt),
    .bit_manip_svc(bit_manip_svc), .fetch_valid(fetch_valid),
    .fetch_addr(acc_addr), .data_valid(data_valid), .data_addr(acc_addr),
    .mem_rom_limit(16'h7fff), .mem_ram_base(16'hfc00),
    .wdt_reset_req(wdt_reset_req),
    .wdt_reset_cause_flag(wdt_reset_cause_flag), .window_open(window_open));
  wwdt_cpu i_cpu (
    .ref_clk(ref_clk), .hready(hready), .hrdata(hrdata), .htrans(htrans),
    .haddr(haddr), .hwrite(hwrite), .hwdata(hwdata),
    .fetch_valid(fetch_valid), .data_valid(data_valid),
    .bit_manip_svc(bit_manip_svc), .acc_addr(acc_addr));
  task automatic close_out();
    if (n_fail == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Signed so negative bounds work; an unknown value still fails
  task automatic rng(input logic signed [31:0] v, input int lo,
                     input int hi);
    chk((v >= lo && v <= hi) ? lo : v, lo);
  endtask
  // Cycles until reset request (0) or open window (1); lim if never
  task automatic wait_hi(input int which, input int lim);
    #1;
    n = 0;
    while ((which ? window_open : wdt_reset_req) !== 1'b1 && n < lim) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask
  task automatic rd_reg(input logic [7:0] a);
    i_cpu.xfer(1'b0, a, 32'h0000_0000, rd);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    i_cpu.xfer(1'b1, a, d, r);
  endtask
  task automatic restart(input logic [7:0] opt);
    @(posedge ref_clk);
    rst <= 1'b1;
    option_byte <= opt;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
  endtask
  initial begin
    restart(8'h30);
    wait_hi(0, 100);
    chk(n, 100);
    rd_reg(OFS_COUNT);
    rng(rd, 45, 56);
    rd_reg(OFS_SERVICE);
    chk(rd, {24'h00_0000, SVC_READ_RUN});
    wr_reg(OFS_SERVICE, SVC_KEY);
    wait_hi(0, 40);
    chk(n, 40);
    rd_reg(OFS_COUNT);
    rng(rd, 16, 28);
    // Clock enable low must freeze divider and counter alike
    rd_reg(OFS_COUNT);
    k = rd;
    ce <= 1'b0;
    repeat (40) @(posedge ref_clk);
    ce <= 1'b1;
    rd_reg(OFS_COUNT);
    rng(rd, k, k + 6);
    wait_hi(1, 3000);
    wr_reg(OFS_SERVICE, SVC_KEY);
    repeat (3) @(posedge ref_clk);
    wait_hi(0, 1);
    chk(window_open, 1'b0);
    wait_hi(1, 3000);
    wr_reg(OFS_SERVICE, SVC_KEY);
    wr_reg(OFS_SERVICE, SVC_KEY);
    wait_hi(0, 8);
    rng(n, 0, 6);
    @(posedge ref_clk);
    wait_hi(0, 3000);
    rng(n, 2040, 2056);
    rd_reg(OFS_CAUSE);
    chk(rd[CAUSE_WDT_BIT], 1'b1);
    rd_reg(OFS_CAUSE);
    chk(rd[CAUSE_WDT_BIT], 1'b0);
    rd_reg(8'h40);
    chk(rd, 32'h0000_0000);
    wr_reg(8'h40, 32'h0000_0055);
    wr_reg(OFS_SERVICE, 32'h0000_0055);
    wait_hi(0, 8);
    rng(n, 0, 6);
    i_cpu.access(2'h2, 16'h0000);
    wait_hi(0, 8);
    rng(n, 0, 6);
    i_cpu.access(2'h1, 16'hfb10);
    wait_hi(0, 20);
    chk(n, 20);
    i_cpu.access(2'h1, 16'h9000);
    wait_hi(0, 8);
    rng(n, 0, 6);
    i_cpu.access(2'h0, 16'h8000);
    wait_hi(0, 8);
    rng(n, 0, 6);
    @(posedge ref_clk);
    halt_mode <= 1'b1;
    rd_reg(OFS_COUNT);
    k = rd;
    repeat (40) @(posedge ref_clk);
    rd_reg(OFS_COUNT);
    chk(rd, k);
    halt_mode <= 1'b0;
    lowspeed_osc_halt <= 1'b1;
    wr_reg(OFS_SERVICE, 32'h0000_0011);
    wait_hi(0, 40);
    chk(n, 40);
    rd_reg(OFS_COUNT);
    chk(rd, k);
    lowspeed_osc_halt <= 1'b0;
    wait_hi(0, 8);
    rng(n, 0, 6);
    // Lock set, overflow code 1: window opens after (1 - open) of 4096
    for (w = 0; w < 4; w++) begin
      restart({1'b0, w[1:0], 1'b1, 3'b001, 1'b1});
      wr_reg(OFS_SERVICE, SVC_KEY);
      repeat (3) @(posedge ref_clk);
      wait_hi(1, 9000);
      rng(n, (3 - w) * 1024 - 12, (3 - w) * 1024 + 4);
    end
    restart(8'h13);
    stop_mode <= 1'b1;
    wait_hi(0, 9000);
    rng(n, 4088, 4104);
    stop_mode <= 1'b0;
    restart(8'h20);
    rd_reg(OFS_SERVICE);
    chk(rd, {24'h00_0000, SVC_READ_STOP});
    i_cpu.access(2'h0, 16'h8000);
    wait_hi(0, 2200);
    chk(n, 2200);
    rd_reg(OFS_COUNT);
    chk(rd, 32'h0000_0000);
    close_out();
  end
  initial begin
    repeat (40000) @(posedge ref_clk);
    n_fail++;
    close_out();
  end
endmodule
`default_nettype wire
